// *** hw/amd_consts.vh ***
// Functional notes
// - the decoder takes a 16-bit address covering a 64 KB space.
// - addresses 0x0000 to 0x005F, except unimplemented 0x0008 and 0x0009, select the zero-page register window.
// - addresses 0x0060 to 0x025F select the 512 bytes of RAM.
// - addresses 0xC000 to 0xEFFF select the 12,288 bytes of user flash.
// - monitor ROM is selected at 0xFC00 to 0xFDFF and at 0xFE10 to 0xFFCF.
// - addresses 0xFFD0 to 0xFFFF select the 48-byte vector table in flash.
// - with illegal-address resets enabled, an access to an unimplemented location requests a reset.
// - 0xFE00 to 0xFE0F, except reserved 0xFE02, 0xFE07, 0xFE0A and 0xFE0B, select the system registers in their fixed order.
// - 0xFFFF also selects the watchdog control register.
// - four port data registers at 0x0000 to 0x0003 keep their contents through reset.
// - four direction registers at 0x0004 to 0x0007 clear to zero on reset.
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH
`define AMD_IO_LO        16'h0000
`define AMD_IO_HI        16'h005F
`define AMD_RAM_LO       16'h0060
`define AMD_RAM_HI       16'h025F
`define AMD_FLASH_LO     16'hC000
`define AMD_FLASH_HI     16'hEFFF
`define AMD_MON1_LO      16'hFC00
`define AMD_MON1_HI      16'hFDFF
`define AMD_SYS_LO       16'hFE00
`define AMD_SYS_HI       16'hFE0F
`define AMD_MON2_LO      16'hFE10
`define AMD_MON2_HI      16'hFFCF
`define AMD_VEC_LO       16'hFFD0
`define AMD_VEC_HI       16'hFFFF
`define AMD_WDOG_ADDR    16'hFFFF
`define AMD_UNIMP_A      16'h0008
`define AMD_UNIMP_B      16'h0009
`define AMD_PORT_DATA_LO 16'h0000
`define AMD_PORT_DIR_LO  16'h0004
`define AMD_DIR_RST      8'h00
`define AMD_SYS_BREAK_STATUS   4'h0
`define AMD_SYS_RESET_STATUS   4'h1
`define AMD_SYS_RSV_2          4'h2
`define AMD_SYS_BREAK_FLAG     4'h3
`define AMD_SYS_IRQ1           4'h4
`define AMD_SYS_IRQ2           4'h5
`define AMD_SYS_IRQ3           4'h6
`define AMD_SYS_RSV_7          4'h7
`define AMD_SYS_FLASH_CTRL     4'h8
`define AMD_SYS_FLASH_PROT     4'h9
`define AMD_SYS_RSV_A          4'hA
`define AMD_SYS_RSV_B          4'hB
`define AMD_SYS_BRK_HIGH       4'hC
`define AMD_SYS_BRK_LOW        4'hD
`define AMD_SYS_BRK_SC         4'hE
`define AMD_SYS_LOW_VOLT       4'hF
`endif

// *** hw/amd_region_decode.v ***
`timescale 1ns/100ps
`include "amd_consts.vh"
module amd_region_decode (
   addr,
   sel_io,
   sel_ram,
   sel_flash,
   sel_mon,
   sel_sys,
   sel_vec,
   sel_wdog,
   sel_unimp,
   sel_rsv
);
   input  wire [15:0] addr;
   output reg         sel_io;
   output reg         sel_ram;
   output reg         sel_flash;
   output reg         sel_mon;
   output reg         sel_sys;
   output reg         sel_vec;
   output reg         sel_wdog;
   output reg         sel_unimp;
   output reg         sel_rsv;

   // ***********************************************
   // region compare on the full 16-bit address
   // ***********************************************
   always @* begin
      sel_io    = (addr <= `AMD_IO_HI) && (addr != `AMD_UNIMP_A) && (addr != `AMD_UNIMP_B);
      sel_ram   = (addr >= `AMD_RAM_LO) && (addr <= `AMD_RAM_HI);
      sel_flash = (addr >= `AMD_FLASH_LO) && (addr <= `AMD_FLASH_HI);
      sel_mon   = ((addr >= `AMD_MON1_LO) && (addr <= `AMD_MON1_HI)) ||
                  ((addr >= `AMD_MON2_LO) && (addr <= `AMD_MON2_HI));
      sel_vec   = (addr >= `AMD_VEC_LO);
      sel_wdog  = (addr == `AMD_WDOG_ADDR);
      sel_sys   = 1'b0;
      sel_rsv   = 1'b0;
      if ((addr >= `AMD_SYS_LO) && (addr <= `AMD_SYS_HI)) begin
         case (addr[3:0])
            `AMD_SYS_RSV_2, `AMD_SYS_RSV_7,
            `AMD_SYS_RSV_A, `AMD_SYS_RSV_B: begin
               sel_rsv = 1'b1;
            end
            default: begin
               sel_sys = 1'b1;
            end
         endcase
      end
      sel_unimp = !(sel_io || sel_ram || sel_flash || sel_mon || sel_vec ||
                    sel_sys || sel_rsv);
   end
endmodule // amd_region_decode

// *** hw/amd_port_bit.v ***
`timescale 1ns/100ps
module amd_port_bit (
   mclk,
   pin_in,
   data_q,
   dir_q,
   pin_sync,
   read_val,
   out_val,
   out_en_n
);
   input  wire mclk;
   input  wire pin_in;
   input  wire data_q;
   input  wire dir_q;
   output wire pin_sync;
   output wire read_val;
   output reg  out_val;
   output reg  out_en_n;

   reg meta_ff;
   reg sync_ff;

   // pin passes two flops before use
   always @(posedge mclk) begin
      meta_ff  <= pin_in;
      sync_ff  <= meta_ff;
      out_val  <= data_q;
      out_en_n <= ~dir_q;
   end

   assign pin_sync = sync_ff;
   assign read_val = dir_q ? data_q : sync_ff;
endmodule // amd_port_bit

// *** hw/amd_map_decoder.v ***
`timescale 1ns/100ps
`include "amd_consts.vh"
module amd_map_decoder #(
   parameter NPORT = 4,
   parameter PW    = 8
) (
   mclk,
   rstn,
   bus_addr,
   bus_valid,
   bus_wr,
   bus_wdata,
   illegal_rst_en,
   port_pin_in,
   bus_rdata,
   sel_io_ff,
   sel_ram_ff,
   sel_flash_ff,
   sel_mon_ff,
   sel_sys_ff,
   sel_sys_idx_ff,
   sel_vec_ff,
   sel_wdog_ff,
   sel_rsv_ff,
   illegal_rst_req_ff,
   port_out,
   port_out_en_n
);
   input  wire                  mclk;
   input  wire                  rstn;
   input  wire [15:0]           bus_addr;
   input  wire                  bus_valid;
   input  wire                  bus_wr;
   input  wire [7:0]            bus_wdata;
   input  wire                  illegal_rst_en;
   input  wire [NPORT*PW-1:0]   port_pin_in;
   output reg  [7:0]            bus_rdata;
   output reg                   sel_io_ff;
   output reg                   sel_ram_ff;
   output reg                   sel_flash_ff;
   output reg                   sel_mon_ff;
   output reg                   sel_sys_ff;
   output reg  [3:0]            sel_sys_idx_ff;
   output reg                   sel_vec_ff;
   output reg                   sel_wdog_ff;
   output reg                   sel_rsv_ff;
   output reg                   illegal_rst_req_ff;
   output wire [NPORT*PW-1:0]   port_out;
   output wire [NPORT*PW-1:0]   port_out_en_n;

   wire                  sel_io;
   wire                  sel_ram;
   wire                  sel_flash;
   wire                  sel_mon;
   wire                  sel_sys;
   wire                  sel_vec;
   wire                  sel_wdog;
   wire                  sel_unimp;
   wire                  sel_rsv;
   reg  [NPORT*PW-1:0]   port_data_ff;
   reg  [NPORT*PW-1:0]   port_dir_ff;
   wire [NPORT*PW-1:0]   port_read;
   reg  [7:0]            nxt_rdata;
   wire                  hit_data;
   wire                  hit_dir;
   wire [1:0]            port_idx;

   amd_region_decode u_dec (
      .addr      (bus_addr),
      .sel_io    (sel_io),
      .sel_ram   (sel_ram),
      .sel_flash (sel_flash),
      .sel_mon   (sel_mon),
      .sel_sys   (sel_sys),
      .sel_vec   (sel_vec),
      .sel_wdog  (sel_wdog),
      .sel_unimp (sel_unimp),
      .sel_rsv   (sel_rsv)
   );

   // ***********************************************
   // registered region selects
   // ***********************************************
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sel_io_ff          <= 1'b0;
         sel_ram_ff         <= 1'b0;
         sel_flash_ff       <= 1'b0;
         sel_mon_ff         <= 1'b0;
         sel_sys_ff         <= 1'b0;
         sel_sys_idx_ff     <= 4'h0;
         sel_vec_ff         <= 1'b0;
         sel_wdog_ff        <= 1'b0;
         sel_rsv_ff         <= 1'b0;
         illegal_rst_req_ff <= 1'b0;
      end else begin
         sel_io_ff          <= bus_valid & sel_io;
         sel_ram_ff         <= bus_valid & sel_ram;
         sel_flash_ff       <= bus_valid & sel_flash;
         sel_mon_ff         <= bus_valid & sel_mon;
         sel_sys_ff         <= bus_valid & sel_sys;
         sel_sys_idx_ff     <= bus_addr[3:0];
         sel_vec_ff         <= bus_valid & sel_vec;
         sel_wdog_ff        <= bus_valid & sel_wdog;
         sel_rsv_ff         <= bus_valid & sel_rsv;
         illegal_rst_req_ff <= bus_valid & sel_unimp & illegal_rst_en;
      end
   end

   // ***********************************************
   // port data and direction registers
   // ***********************************************
   // full 16-bit compare with the two index bits masked off
   assign hit_data = bus_valid && ((bus_addr & 16'hFFFC) == `AMD_PORT_DATA_LO);
   assign hit_dir  = bus_valid && ((bus_addr & 16'hFFFC) == `AMD_PORT_DIR_LO);
   assign port_idx = bus_addr[1:0];

   genvar gp;
   genvar gb;
   generate
      for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_port
         // data latch has no reset
         always @(posedge mclk) begin
            if (bus_wr && hit_data && (port_idx == gp)) begin
               port_data_ff[gp*PW +: PW] <= bus_wdata;
            end
         end
         always @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               port_dir_ff[gp*PW +: PW] <= `AMD_DIR_RST;
            end else if (bus_wr && hit_dir && (port_idx == gp)) begin
               port_dir_ff[gp*PW +: PW] <= bus_wdata;
            end
         end
         for (gb = 0; gb < PW; gb = gb + 1) begin : g_bit
            amd_port_bit u_bit (
               .mclk     (mclk),
               .pin_in   (port_pin_in[gp*PW+gb]),
               .data_q   (port_data_ff[gp*PW+gb]),
               .dir_q    (port_dir_ff[gp*PW+gb]),
               .pin_sync (),
               .read_val (port_read[gp*PW+gb]),
               .out_val  (port_out[gp*PW+gb]),
               .out_en_n (port_out_en_n[gp*PW+gb])
            );
         end
      end
   endgenerate

   // ***********************************************
   // read data, one cycle after the request
   // ***********************************************
   always @* begin
      nxt_rdata = 8'h00;
      if (bus_valid && !bus_wr && hit_data) begin
         nxt_rdata = port_read[port_idx*PW +: PW];
      end else if (bus_valid && !bus_wr && hit_dir) begin
         nxt_rdata = port_dir_ff[port_idx*PW +: PW];
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= nxt_rdata;
      end
   end
endmodule // amd_map_decoder

// *** verif/amd_map_sva.sv ***
`timescale 1ns/100ps
// ********
// map checks
// ********
module amd_map_sva #(
   parameter NPORT = 4,
   parameter PW    = 8
) (
   input wire                mclk,
   input wire                rstn,
   input wire [15:0]         bus_addr,
   input wire                bus_valid,
   input wire                bus_wr,
   input wire [7:0]          bus_wdata,
   input wire                illegal_rst_en,
   input wire [NPORT*PW-1:0] port_pin_in,
   input wire [7:0]          bus_rdata,
   input wire                sel_io_ff,
   input wire                sel_ram_ff,
   input wire                sel_flash_ff,
   input wire                sel_mon_ff,
   input wire                sel_sys_ff,
   input wire [3:0]          sel_sys_idx_ff,
   input wire                sel_vec_ff,
   input wire                sel_wdog_ff,
   input wire                sel_rsv_ff,
   input wire                illegal_rst_req_ff,
   input wire [NPORT*PW-1:0] port_out,
   input wire [NPORT*PW-1:0] port_out_en_n
);
   wire [15:0] a = bus_addr;
   wire unimp = a == 16'h0008 || a == 16'h0009 || (a >= 16'h0260 && a <= 16'hBFFF)
      || (a >= 16'hF000 && a <= 16'hFBFF);
   wire rsvd = a[15:4] == 12'hFE0 && (a[3:0] == 4'h2 || a[3:0] == 4'h7 || a[3:1] == 3'h5);
   wire hit = bus_valid & unimp & illegal_rst_en;
   reg [15:0] a_ff;
   always @(posedge mclk) a_ff <= a;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   io_sel_a: assert property (
      bus_valid && a <= 16'h005F && !unimp |=> sel_io_ff) else $error("io select");
   ram_sel_a: assert property (
      bus_valid && a >= 16'h0060 && a <= 16'h025F |=> sel_ram_ff) else $error("ram select");
   flash_sel_a: assert property (
      bus_valid && a >= 16'hC000 && a <= 16'hEFFF |=> sel_flash_ff) else $error("flash select");
   mon_sel_a: assert property (
      bus_valid && ((a >= 16'hFC00 && a <= 16'hFDFF) || (a >= 16'hFE10 && a <= 16'hFFCF))
      |=> sel_mon_ff) else $error("monitor select");
   vec_wdog_a: assert property (
      bus_valid && a == 16'hFFFF |=> sel_vec_ff && sel_wdog_ff) else $error("vector select");
   illegal_req_a: assert property (
      1'b1 |=> illegal_rst_req_ff == $past(hit)) else $error("illegal request");
   sys_sel_a: assert property (
      bus_valid && a[15:4] == 12'hFE0 && !rsvd |=> sel_sys_ff && sel_sys_idx_ff == a_ff[3:0])
      else $error("system select");
   dir_drive_a: assert property (
      bus_valid && bus_wr && a == 16'h0004 |=> ##1 port_out_en_n[7:0] == ~$past(bus_wdata, 2))
      else $error("direction drive");
   read_zero_a: assert property (
      bus_valid && !bus_wr && a > 16'h0007 |=> bus_rdata == 8'h00) else $error("read zero");
   cover property (hit);
   cover property (bus_valid && a == 16'hFFFF);
   cover property (bus_valid && bus_wr && a == 16'h0004);
endmodule // amd_map_sva
bind amd_map_decoder amd_map_sva #(.NPORT(NPORT), .PW(PW)) u_amd_map_sva (
   .mclk(mclk), .rstn(rstn), .bus_addr(bus_addr), .bus_valid(bus_valid), .bus_wr(bus_wr),
   .bus_wdata(bus_wdata), .illegal_rst_en(illegal_rst_en), .port_pin_in(port_pin_in),
   .bus_rdata(bus_rdata), .sel_io_ff(sel_io_ff), .sel_ram_ff(sel_ram_ff),
   .sel_flash_ff(sel_flash_ff), .sel_mon_ff(sel_mon_ff), .sel_sys_ff(sel_sys_ff),
   .sel_sys_idx_ff(sel_sys_idx_ff), .sel_vec_ff(sel_vec_ff), .sel_wdog_ff(sel_wdog_ff),
   .sel_rsv_ff(sel_rsv_ff), .illegal_rst_req_ff(illegal_rst_req_ff),
   .port_out(port_out), .port_out_en_n(port_out_en_n));

// *** verif/amd_core_model.sv ***
`timescale 1ns/100ps
module amd_core_model (
   input wire          mclk,
   output logic [15:0] bus_addr,
   output logic        bus_valid,
   output logic        bus_wr,
   output logic [7:0]  bus_wdata
);
   initial begin
      bus_addr = 16'h0000;
      bus_valid = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 8'h00;
   end
   // one access, held through the taking edge
   task automatic acc(input [15:0] a, input w, input [7:0] d);
      bus_valid <= 1'b1;
      bus_addr <= a;
      bus_wr <= w;
      bus_wdata <= d;
      @(posedge mclk);
   endtask
   // released address and data lines do not keep the last value; bus_wr does
   task automatic idle;
      bus_valid <= 1'b0;
      bus_addr <= ~bus_addr;
      bus_wdata <= ~bus_wdata;
      @(posedge mclk);
   endtask
endmodule // amd_core_model

// *** verif/tb_mcu_address_map_decoder.sv ***
`timescale 1ns/100ps
module tb_mcu_address_map_decoder;
   logic        mclk, rstn, illegal_rst_en, v_d;
   logic [31:0] port_pin_in;
   wire  [15:0] bus_addr;
   wire         bus_valid, bus_wr, io, ram, fl, mon, sys, vec, wd, rsv, ill;
   wire  [7:0]  bus_wdata, bus_rdata;
   wire  [3:0]  sidx;
   wire  [31:0] port_out, port_out_en_n;
   logic [7:0]  lat [4], dir [4];
   logic [21:0] q [$];
   logic [15:0] tbl [18] = '{16'h005F, 16'h0060, 16'h025F, 16'h0260, 16'hBFFF, 16'hC000,
      16'hEFFF, 16'hF000, 16'hFBFF, 16'hFC00, 16'hFDFF, 16'hFE10, 16'hFFCF, 16'hFFD0,
      16'hFFFF, 16'h0008, 16'h0009, 16'h000A};
   int          bad_count, n_tests, cyc, i, k;
   integer      seed;
   amd_core_model u_amd_core_model (.mclk(mclk), .bus_addr(bus_addr), .bus_valid(bus_valid),
      .bus_wr(bus_wr), .bus_wdata(bus_wdata));
   amd_map_decoder u_amd_map_decoder (.mclk(mclk), .rstn(rstn), .bus_addr(bus_addr),
      .bus_valid(bus_valid), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
      .illegal_rst_en(illegal_rst_en), .port_pin_in(port_pin_in), .bus_rdata(bus_rdata),
      .sel_io_ff(io), .sel_ram_ff(ram), .sel_flash_ff(fl), .sel_mon_ff(mon), .sel_sys_ff(sys),
      .sel_sys_idx_ff(sidx), .sel_vec_ff(vec), .sel_wdog_ff(wd), .sel_rsv_ff(rsv),
      .illegal_rst_req_ff(ill), .port_out(port_out), .port_out_en_n(port_out_en_n));
   wire  [20:0] got = {sidx, io, ram, fl, mon, sys, vec, wd, rsv, ill, bus_rdata};
   // ********
   // checking
   // ********
   task automatic chk(input [31:0] e, input [31:0] a);
      n_tests++;
      if (a !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic [21:0] expv(input [15:0] a, input w);
      logic u;
      logic [7:0] r;
      u = a == 16'h0008 || a == 16'h0009 || (a >= 16'h0260 && a <= 16'hBFFF)
         || (a >= 16'hF000 && a <= 16'hFBFF);
      r = 8'h00;
      if (!w && a <= 16'h0003)
         r = (lat[a[1:0]] & dir[a[1:0]]) | (port_pin_in[a[1:0]*8 +: 8] & ~dir[a[1:0]]);
      else if (!w && a <= 16'h0007)
         r = dir[a[1:0]];
      expv = {a[3:0], w, a <= 16'h005F && !u, a >= 16'h0060 && a <= 16'h025F,
         a >= 16'hC000 && a <= 16'hEFFF,
         (a >= 16'hFC00 && a <= 16'hFDFF) || (a >= 16'hFE10 && a <= 16'hFFCF),
         a[15:4] == 12'hFE0, a >= 16'hFFD0, a == 16'hFFFF, 1'b0, u & illegal_rst_en, r};
   endfunction
   task automatic op(input [15:0] a, input w, input [7:0] d);
      if (a[15:4] == 12'hFE0 && (a[3:0] == 4'h2 || a[3:0] == 4'h7 || a[3:1] == 3'h5)) return;
      q.push_back(expv(a, w));
      if (w && a <= 16'h0007) begin
         if (a[2]) dir[a[1:0]] = d;
         else lat[a[1:0]] = d;
      end
      u_amd_core_model.acc(a, w, d);
   endtask
   always @(posedge mclk) v_d <= bus_valid;
   always @(negedge mclk) begin : mon_blk
      logic [21:0] e;
      if (v_d && rstn) begin
         e = q.pop_front();
         chk({e[21:18], e[16:0]}, got);
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         close_out();
      end
   end
   // ********
   // stimulus
   // ********
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      seed = 32'h1bf5;
      rstn = 1'b0;
      illegal_rst_en = 1'b0;
      port_pin_in = $random(seed);
      for (i = 0; i < 4; i++) dir[i] = 8'h00;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      for (i = 4; i < 8; i++) op(i, 1'b0, 8'h00);
      for (i = 0; i < 4; i++) begin
         op(4 + i, 1'b1, $random(seed));
         op(i, 1'b1, $random(seed));
      end
      for (i = 0; i < 8; i++) op(i, 1'b0, 8'h00);
      u_amd_core_model.idle();
      @(negedge mclk);
      chk({lat[3], lat[2], lat[1], lat[0]}, port_out);
      chk(~{dir[3], dir[2], dir[1], dir[0]}, port_out_en_n);
      @(posedge mclk);
      $display("test ports done");
      for (k = 0; k < 2; k++) begin
         illegal_rst_en <= k[0];
         u_amd_core_model.idle();
         foreach (tbl[i]) op(tbl[i], k[0], $random(seed));
         for (i = 0; i < 16; i++) op(16'hFE00 + i, k[0], 8'h00);
      end
      $display("test regions done");
      port_pin_in <= $random(seed);
      repeat (3) u_amd_core_model.idle();
      repeat (200) begin
         i = $random(seed);
         op(i[15] ? i[15:0] & 16'h0007 : i[15:0], i[16], i[24:17]);
      end
      $display("test random done");
      u_amd_core_model.idle();
      rstn <= 1'b0;
      repeat (3) u_amd_core_model.idle();
      for (i = 0; i < 4; i++) dir[i] = 8'h00;
      rstn <= 1'b1;
      u_amd_core_model.idle();
      @(negedge mclk);
      chk({lat[3], lat[2], lat[1], lat[0]}, port_out);
      chk(32'hFFFFFFFF, port_out_en_n);
      @(posedge mclk);
      for (i = 0; i < 8; i++) op(i, 1'b0, 8'h00);
      repeat (2) u_amd_core_model.idle();
      chk(0, q.size());
      $display("test reset done");
      close_out();
   end
endmodule // tb_mcu_address_map_decoder
